// ---- serial_slave_pkg.sv ----
// Shared constants and types for the dual serial register slave.
// Assumes one system clock and a host-driven serial clock.
package serial_slave_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CONFIG_ADDR    = 8'hf5;
  localparam int unsigned THREE_WIRE_BIT = 0;
  localparam logic [7:0] CONFIG_RESET   = 8'h00;
  localparam logic       SPI_ADDR_TOP   = 1'b1;
  localparam logic [7:0] ADDR_STEP      = 8'h01;

  // ************************************************************
  // Two-wire addressing and byte framing
  // ************************************************************
  localparam logic [5:0] I2C_ADDR_FIXED = 6'h3b;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [2:0] SPI_LAST_BIT   = 3'h7;

  // ************************************************************
  // Pin synchroniser lanes and their idle levels
  // ************************************************************
  localparam int unsigned LANES    = 5;
  localparam int unsigned IN_CSB   = 0;
  localparam int unsigned IN_SCK   = 1;
  localparam int unsigned IN_SDI   = 2;
  localparam int unsigned IN_SEL   = 3;
  localparam int unsigned IN_TGL   = 4;
  localparam logic [4:0]  IDLE_LVL = 5'h07;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_RX,
    I2C_ACK,
    I2C_TX,
    I2C_MACK
  } i2c_state_t;

endpackage

// ---- spi_link.sv ----
// SPI shift engine clocked by the host serial clock.
// Assumes the caller reads the register array combinationally at rd_addr_o.
`timescale 1ns/1ps
`default_nettype none
module spi_link
  import serial_slave_pkg::*;
(
  input  wire logic       rst_i,
  input  wire logic       sck_i,
  input  wire logic       csb_n_i,
  input  wire logic       sdi_i,
  input  wire logic       three_wire_i,
  input  wire logic [7:0] rd_data_i,
  output logic      [7:0] rd_addr_o,
  output logic      [7:0] wr_addr_o,
  output logic      [7:0] wr_data_o,
  output logic            wr_toggle_o,
  output logic            data_o,
  output logic            sdo_oe_n_o,
  output logic            sdi_oe_n_o
);

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic       ctrl_phase;
    logic       reading;
    logic [7:0] addr;
    logic [7:0] tx;
    logic [1:0] tw_sync;
  } frame_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       toggle;
  } held_t;

  frame_t     frame_reg;
  frame_t     frame_next;
  held_t      held_reg;
  held_t      held_next;
  logic       out_reg;
  logic       drive_reg;
  logic [7:0] rx_byte;

  // ************************************************************
  // Byte assembly on rising edges
  // ************************************************************
  always_comb begin
    rx_byte    = {frame_reg.shift, sdi_i};                              // [R22]
    frame_next = frame_reg;
    held_next  = held_reg;
    rd_addr_o  = frame_reg.ctrl_phase ? {SPI_ADDR_TOP, rx_byte[6:0]}
                                      : frame_reg.addr + ADDR_STEP;
    frame_next.tw_sync = {frame_reg.tw_sync[0], three_wire_i};
    frame_next.shift   = rx_byte[6:0];                                  // [R14]
    frame_next.bit_cnt = frame_reg.bit_cnt + 3'h1;
    frame_next.tx      = {frame_reg.tx[6:0], 1'b0};
    if (frame_reg.bit_cnt == SPI_LAST_BIT) begin
      if (frame_reg.ctrl_phase) begin
        frame_next.addr       = {SPI_ADDR_TOP, rx_byte[6:0]};           // [R16]
        frame_next.reading    = rx_byte[7];
        frame_next.ctrl_phase = 1'b0;
        if (rx_byte[7]) begin
          frame_next.tx = rd_data_i;                                    // [R18]
        end
      end else if (frame_reg.reading) begin
        frame_next.addr = frame_reg.addr + ADDR_STEP;                   // [R18]
        frame_next.tx   = rd_data_i;
      end else begin
        held_next.addr        = frame_reg.addr;                         // [R17]
        held_next.data        = rx_byte;
        held_next.toggle      = ~held_reg.toggle;
        frame_next.ctrl_phase = 1'b1;
      end
    end
  end

  // Raising chip select ends the frame at once
  always_ff @(posedge sck_i or posedge csb_n_i) begin                   // [R15]
    if (csb_n_i) begin                                                  // [R13]
      frame_reg            <= '0;
      frame_reg.ctrl_phase <= 1'b1;
    end else begin
      frame_reg <= frame_next;
    end
  end

  // Survives frame ends so the toggle never fakes a write
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      held_reg <= '0;
    end else begin
      held_reg <= held_next;
    end
  end

  // ************************************************************
  // Output bit changes on falling edges
  // ************************************************************
  always_ff @(negedge sck_i or posedge csb_n_i) begin
    if (csb_n_i) begin
      out_reg   <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      out_reg   <= frame_reg.tx[7];                                     // [R14]
      drive_reg <= frame_reg.reading;
    end
  end

  assign data_o      = out_reg;
  assign sdo_oe_n_o  = ~(drive_reg & ~frame_reg.tw_sync[1]);            // [R12]
  assign sdi_oe_n_o  = ~(drive_reg & frame_reg.tw_sync[1]);             // [R11]
  assign wr_addr_o   = held_reg.addr;
  assign wr_data_o   = held_reg.data;
  assign wr_toggle_o = held_reg.toggle;

endmodule
`default_nettype wire

// ---- dual_serial_register_slave.sv ----
// Byte-wide register map reachable over a two-wire slave or an SPI slave.
// Assumes pins arrive unsynchronised and srst_i acts as power-on reset.
//
// Behaviour
// R1 - Two-wire clock pin is input only; never stretched.
// R2 - Standard, fast and high-speed two-wire transfers are accepted.
// R3 - Two-wire address is six fixed upper bits plus one variable bit.
// R4 - Address low bit follows the select pin live: 0x76 or 0x77.
// R5 - System holds chip select high to use the two-wire port.
// R6 - Two-wire data pin is only pulled low or released.
// R7 - Two-wire writes carry address/data pairs; each byte lands at its address.
// R8 - Host writes the pointer, restarts or stops, then reads.
// R9 - Two-wire reads return incrementing addresses until not-acknowledge and stop.
// R10 - SPI mode 00 or 11 chosen from clock level after select falls.
// R11 - Three-wire enable set makes the data-in pad bidirectional.
// R12 - In three-wire operation the serial output pin stays released.
// R13 - Chip select is active low and idles high when undriven.
// R14 - SPI samples on rising clock, changes output on falling clock.
// R15 - SPI frame starts on select fall, ends on rise; clock steady then.
// R16 - SPI control byte: top bit direction, low seven bits address.
// R17 - SPI writes are control/data pairs until select rises.
// R18 - SPI reads stream from the address onward, incrementing.
// R19 - Select driven low once disables the two-wire port until reset.
// R20 - Three-wire enable lives in bit 0 of register 0xF5.
// R21 - Slave acknowledges address and written bytes, releases for master.
// R22 - Every byte moves most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module dual_serial_register_slave
  import serial_slave_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       csb_n_i,
  input  wire logic       sck_i,
  input  wire logic       sdi_i,
  output logic            sdi_o,
  output logic            sdi_oe_n_o,
  input  wire logic       sdo_i,
  output logic            sdo_o,
  output logic            sdo_oe_n_o,
  input  wire logic       core_we_i,
  input  wire logic [7:0] core_addr_i,
  input  wire logic [7:0] core_wdata_i,
  output logic      [7:0] core_rdata_o,
  output logic            host_wr_o,
  output logic      [7:0] host_wr_addr_o,
  output logic      [7:0] host_wr_data_o,
  output logic            three_wire_enable_o,
  output logic            i2c_disabled_o,
  output logic            spi_mode_o
);

  typedef struct packed {
    // Raw pin stages, then the agreed level per lane
    logic [2:0][LANES-1:0] sync;
    logic [LANES-1:0]      filt;
    logic                  lock;
    logic                  spi_mode;
    logic [7:0]            cfg;
    i2c_state_t            state;
    logic [3:0]            bit_cnt;
    logic [7:0]            shift;
    logic [7:0]            tx;
    logic [7:0]            ptr;
    logic                  rw;
    logic                  expect_data;
    logic                  pull;
    logic                  cont;
    logic                  wr;
    logic [7:0]            wr_addr;
    logic [7:0]            wr_data;
    logic [7:0]            core_rdata;
  } main_state_t;

  main_state_t      s_reg;
  main_state_t      s_next;
  logic [7:0]       mem [256];
  logic             mem_we;
  logic [7:0]       mem_waddr;
  logic [7:0]       mem_wdata;
  logic [7:0]       i2c_rd_addr;
  logic [7:0]       i2c_rd_data;
  logic [7:0]       spi_rd_addr;
  logic [7:0]       spi_rd_data;
  logic [7:0]       core_rd_data;
  logic [7:0]       spi_wr_addr;
  logic [7:0]       spi_wr_data;
  logic             spi_wr_toggle;
  logic             spi_data;
  logic             spi_sdo_oe_n;
  logic             spi_sdi_oe_n;
  logic [LANES-1:0] raw;
  logic             i2c_active;

  // ************************************************************
  // SPI engine on the host clock
  // ************************************************************
  spi_link u_spi (
    .rst_i        (srst_i),
    .sck_i        (sck_i),
    .csb_n_i      (csb_n_i),
    .sdi_i        (sdi_i),
    .three_wire_i (s_reg.cfg[THREE_WIRE_BIT]),
    .rd_data_i    (spi_rd_data),
    .rd_addr_o    (spi_rd_addr),
    .wr_addr_o    (spi_wr_addr),
    .wr_data_o    (spi_wr_data),
    .wr_toggle_o  (spi_wr_toggle),
    .data_o       (spi_data),
    .sdo_oe_n_o   (spi_sdo_oe_n),
    .sdi_oe_n_o   (spi_sdi_oe_n)
  );

  // ************************************************************
  // Register array read ports
  // ************************************************************
  // SPI has half a bit time to fetch, so it reads the array directly;
  // a byte rewritten in that instant may be seen torn
  assign i2c_rd_addr  = (s_reg.state == I2C_MACK) ? s_reg.ptr + ADDR_STEP : s_reg.ptr;
  assign i2c_rd_data  = (i2c_rd_addr == CONFIG_ADDR) ? s_reg.cfg : mem[i2c_rd_addr];
  assign spi_rd_data  = (spi_rd_addr == CONFIG_ADDR) ? s_reg.cfg : mem[spi_rd_addr];
  assign core_rd_data = (core_addr_i == CONFIG_ADDR) ? s_reg.cfg : mem[core_addr_i];
  // Toggle rides the pin filter, so an SPI write crosses like a pin
  assign raw          = {spi_wr_toggle, sdo_i, sdi_i, sck_i, csb_n_i};
  assign i2c_active   = ~s_reg.lock & s_reg.filt[IN_CSB];

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic i2c_on;
    scl       = 1'b0;
    sda       = 1'b0;
    scl_rise  = 1'b0;
    scl_fall  = 1'b0;
    start     = 1'b0;
    stop      = 1'b0;
    i2c_on    = 1'b0;

    s_next    = s_reg;
    mem_we    = 1'b0;
    mem_waddr = s_reg.ptr;
    mem_wdata = s_reg.shift;
    s_next.wr = 1'b0;

    // Three stages; a change counts once stages two and three agree
    s_next.sync[0] = raw;                                               // [R2]
    s_next.sync[1] = s_reg.sync[0];
    s_next.sync[2] = s_reg.sync[1];
    for (int i = 0; i < LANES; i++) begin
      if (s_reg.sync[1][i] == s_reg.sync[2][i]) begin
        s_next.filt[i] = s_reg.sync[2][i];
      end
    end

    scl      = s_next.filt[IN_SCK];                                     // [R1]
    sda      = s_next.filt[IN_SDI];
    scl_rise = scl & ~s_reg.filt[IN_SCK];
    scl_fall = ~scl & s_reg.filt[IN_SCK];
    start    = scl & s_reg.filt[IN_SCK] & s_reg.filt[IN_SDI] & ~sda;
    stop     = scl & s_reg.filt[IN_SCK] & ~s_reg.filt[IN_SDI] & sda;

    // Any low select, clocked or not, locks out the two-wire port
    if (~s_next.filt[IN_CSB]) begin
      s_next.lock = 1'b1;                                               // [R19]
    end
    if (s_reg.filt[IN_CSB] & ~s_next.filt[IN_CSB]) begin
      s_next.spi_mode = s_next.filt[IN_SCK];                            // [R10]
    end
    i2c_on = ~s_next.lock & s_next.filt[IN_CSB];                        // [R5]

    // SPI write handed over by toggle; its data is held for two byte times
    if (s_reg.filt[IN_TGL] != s_next.filt[IN_TGL]) begin
      mem_we         = 1'b1;
      mem_waddr      = spi_wr_addr;
      mem_wdata      = spi_wr_data;
      s_next.wr      = 1'b1;
    end

    // Start or stop at any time aborts the byte in flight
    if (!i2c_on || stop) begin
      s_next.state = I2C_IDLE;
      s_next.pull  = 1'b0;
    end else if (start) begin
      s_next.state       = I2C_ADDR;
      s_next.bit_cnt     = 4'h0;
      s_next.pull        = 1'b0;
      s_next.expect_data = 1'b0;
    end else begin
      case (s_reg.state)
        I2C_IDLE: begin
          s_next.pull = 1'b0;
        end
        I2C_ADDR, I2C_RX: begin
          if (scl_rise) begin
            s_next.shift   = {s_reg.shift[6:0], sda};                   // [R22]
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
          if (scl_fall && s_reg.bit_cnt == BITS_PER_BYTE) begin
            if (s_reg.state == I2C_ADDR) begin
              if (s_reg.shift[7:1] == {I2C_ADDR_FIXED, s_reg.filt[IN_SEL]}) begin // [R3] [R4]
                s_next.pull  = 1'b1;                                    // [R21]
                s_next.rw    = s_reg.shift[0];
                s_next.tx    = i2c_rd_data;                             // [R8]
                s_next.state = I2C_ACK;
              end else begin
                // Foreign address: stay off the bus until the next start
                s_next.state = I2C_IDLE;
              end
            end else begin
              s_next.pull  = 1'b1;                                      // [R21]
              s_next.state = I2C_ACK;
              if (s_reg.expect_data) begin
                mem_we             = 1'b1;                              // [R7]
                mem_waddr          = s_reg.ptr;
                mem_wdata          = s_reg.shift;
                s_next.wr          = 1'b1;
                s_next.expect_data = 1'b0;
              end else begin
                // Pointer kept across stop so a bare pointer sets up reads
                s_next.ptr         = s_reg.shift;                       // [R7]
                s_next.expect_data = 1'b1;
              end
            end
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            s_next.bit_cnt = 4'h0;
            if (s_reg.rw) begin
              s_next.pull  = ~s_reg.tx[7];                              // [R6]
              s_next.state = I2C_TX;
            end else begin
              s_next.pull  = 1'b0;
              s_next.state = I2C_RX;
            end
          end
        end
        I2C_TX: begin
          // Bits change after the filtered fall, which gives the hold time
          if (scl_rise) begin
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
          if (scl_fall) begin
            if (s_reg.bit_cnt == BITS_PER_BYTE) begin
              s_next.pull  = 1'b0;                                      // [R21]
              s_next.state = I2C_MACK;
            end else begin
              s_next.pull = ~s_reg.tx[6];                               // [R22]
              s_next.tx   = {s_reg.tx[6:0], 1'b0};
            end
          end
        end
        I2C_MACK: begin
          // Next byte fetched at the acknowledge, ready for the fall
          if (scl_rise) begin
            s_next.cont = ~sda;                                         // [R9]
            if (~sda) begin
              s_next.ptr = s_reg.ptr + ADDR_STEP;                       // [R9]
              s_next.tx  = i2c_rd_data;
            end
          end
          if (scl_fall) begin
            if (s_reg.cont) begin
              s_next.pull    = ~s_reg.tx[7];
              s_next.bit_cnt = 4'h0;
              s_next.state   = I2C_TX;
            end else begin
              s_next.state = I2C_IDLE;
            end
          end
        end
        default: begin
          s_next.state = I2C_IDLE;
          s_next.pull  = 1'b0;
        end
      endcase
    end

    // Host writes win over the core port in a shared cycle
    if (!mem_we && core_we_i) begin
      mem_we    = 1'b1;
      mem_waddr = core_addr_i;
      mem_wdata = core_wdata_i;
    end
    if (mem_we && mem_waddr == CONFIG_ADDR) begin
      s_next.cfg = mem_wdata;                                           // [R20]
    end
    if (s_next.wr) begin
      s_next.wr_addr = mem_waddr;
      s_next.wr_data = mem_wdata;
    end
    // Registered read keeps the core latency at one cycle
    s_next.core_rdata = core_rd_data;
  end

  // ************************************************************
  // State and array registers
  // ************************************************************
  // Idle levels preloaded so release fakes no start, stop or select edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s_reg        <= '0;
      s_reg.sync   <= {3{IDLE_LVL}};                                    // [R13]
      s_reg.filt   <= IDLE_LVL;
      s_reg.cfg    <= CONFIG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Array left unreset; only the config byte has a defined start
  always_ff @(posedge clock_i) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ************************************************************
  // Pads
  // ************************************************************
  // Two-wire side only ever pulls low; SPI owns the pads once locked
  assign sdi_o               = i2c_active ? 1'b0 : spi_data;           // [R6]
  assign sdi_oe_n_o          = i2c_active ? ~s_reg.pull : spi_sdi_oe_n;
  assign sdo_o               = spi_data;
  assign sdo_oe_n_o          = spi_sdo_oe_n;                            // [R12]
  assign core_rdata_o        = s_reg.core_rdata;
  assign host_wr_o           = s_reg.wr;
  assign host_wr_addr_o      = s_reg.wr_addr;
  assign host_wr_data_o      = s_reg.wr_data;
  assign three_wire_enable_o = s_reg.cfg[THREE_WIRE_BIT];               // [R11]
  assign i2c_disabled_o      = s_reg.lock;
  assign spi_mode_o          = s_reg.spi_mode;

endmodule
`default_nettype wire

// ---- dual_serial_register_slave_chk.sv ----
// Port assertions for the dual serial register slave.
// Assumes raw pins are sampled on clock_i, as the slave does.
`timescale 1ns/1ps
`default_nettype none
module dual_serial_register_slave_chk
  import serial_slave_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       csb_n_i,
  input  wire logic       sck_i,
  input  wire logic       sdi_o,
  input  wire logic       sdi_oe_n_o,
  input  wire logic       sdo_oe_n_o,
  input  wire logic       core_we_i,
  input  wire logic [7:0] core_addr_i,
  input  wire logic       host_wr_o,
  input  wire logic [7:0] host_wr_addr_o,
  input  wire logic [7:0] host_wr_data_o,
  input  wire logic       three_wire_enable_o,
  input  wire logic       i2c_disabled_o,
  input  wire logic       spi_mode_o
);
  // ********************************
  // Properties
  // ********************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence sel_fall_s;
    $fell(csb_n_i);
  endsequence
  sdo_idle_a: assert property (csb_n_i |-> sdo_oe_n_o)
    else $error("sdo driven while deselected");
  sdo_three_wire_a: assert property (three_wire_enable_o |-> sdo_oe_n_o)
    else $error("sdo driven in three-wire operation");
  pull_low_only_a: assert property (!sdi_oe_n_o && csb_n_i && !i2c_disabled_o |-> !sdi_o)
    else $error("two-wire data driven high");
  lock_set_a: assert property (sel_fall_s |-> ##[1:6] i2c_disabled_o)
    else $error("select fall did not lock two-wire port");
  lock_hold_a: assert property (i2c_disabled_o |=> i2c_disabled_o && (!csb_n_i || sdi_oe_n_o))
    else $error("two-wire lock dropped or port active");
  mode_high_a: assert property (sel_fall_s ##0 sck_i |-> ##[1:6] spi_mode_o)
    else $error("mode 11 not selected");
  mode_low_a: assert property (sel_fall_s ##0 !sck_i |-> ##[1:6] !spi_mode_o)
    else $error("mode 00 not selected");
  wr_pulse_a: assert property (host_wr_o |=> !host_wr_o)
    else $error("host write pulse too long");
  cfg_value_a: assert property (host_wr_o && host_wr_addr_o == CONFIG_ADDR
    |-> ##[0:1] three_wire_enable_o == host_wr_data_o[THREE_WIRE_BIT])
    else $error("three-wire enable not taken from write");
  cfg_cause_a: assert property ($changed(three_wire_enable_o)
    |-> $past(core_we_i && core_addr_i == CONFIG_ADDR) || host_wr_o || $past(host_wr_o))
    else $error("three-wire enable changed without a write");
endmodule
bind dual_serial_register_slave dual_serial_register_slave_chk chk (.clock_i, .srst_i, .csb_n_i, .sck_i,
  .sdi_o, .sdi_oe_n_o, .sdo_oe_n_o, .core_we_i, .core_addr_i, .host_wr_o, .host_wr_addr_o, .host_wr_data_o,
  .three_wire_enable_o, .i2c_disabled_o, .spi_mode_o);
`default_nettype wire

// ---- serial_host_model.sv ----
// Behavioural host: two-wire master and SPI master.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input  wire logic dut_sdi_i,
  input  wire logic dut_sdi_oe_n_i,
  input  wire logic dut_sdo_i,
  input  wire logic dut_sdo_oe_n_i,
  output logic      csb_n_o,
  output logic      sck_o,
  output logic      pad_o
);
  localparam int Q = 125;
  logic drv;
  // ********************************
  // Pads and transfers
  // ********************************
  // Wired pad with pull-up; either side may pull low
  assign pad_o = drv & (dut_sdi_oe_n_i | dut_sdi_i);
  initial begin
    sck_o = 1'b1;
    drv = 1'b1;
    #1 csb_n_o = 1'b1;
  end
  // Also serves as repeated start
  task automatic i2c_start();
    #Q drv = 1'b1;
    #Q sck_o = 1'b1;
    #Q drv = 1'b0;
    #Q sck_o = 1'b0;
  endtask
  task automatic i2c_stop();
    #Q drv = 1'b0;
    #Q sck_o = 1'b1;
    #Q drv = 1'b1;
    #Q;
  endtask
  // Long low phase leaves room for the slave's input filter
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    logic [8:0] got;
    sh = {tx, ack_in};
    for (int i = 0; i < 9; i++) begin
      #Q drv = sh[8];
      #Q sck_o = 1'b1;
      #Q got = {got[7:0], pad_o};
      #Q sck_o = 1'b0;
      sh = sh << 1;
    end
    rx = got[8:1];
    ack = got[0];
  endtask
  task automatic spi_begin(input logic idle);
    sck_o = idle;
    #Q csb_n_o = 1'b0;
    #Q;
  endtask
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      drv = tx[i];
      #32 rx[i] = dut_sdo_oe_n_i ? pad_o : dut_sdo_i;
      sck_o = 1'b1;
      #32;
    end
  endtask
  task automatic spi_end(input logic idle);
    sck_o = idle;
    #Q csb_n_o = 1'b1;
    #Q drv = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dual_serial_register_slave_tb_top.sv ----
// Self-checking bench for the dual serial register slave.
// Assumes the host model owns the pins except sdo_i, and the bench sdo_i and the core side.
`timescale 1ns/1ps
`default_nettype none
`define check(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error %s expected %h seen %h", name, exp, got); end end
module dual_serial_register_slave_tb_top
  import serial_slave_pkg::*;
;
  logic clock_i, srst_i, csb_n_i, sck_i, sdi_i, sdi_o, sdi_oe_n_o, sdo_i, sdo_o, sdo_oe_n_o;
  logic core_we_i, host_wr_o, three_wire_enable_o, i2c_disabled_o, spi_mode_o;
  logic [7:0] core_addr_i, core_wdata_i, core_rdata_o, host_wr_addr_o, host_wr_data_o, rx, base;
  logic [7:0] d [2];
  logic [7:0] e [3];
  logic [15:0] exp_q [$];
  logic [15:0] exp_w;
  logic ack;
  int num_errors, num_checks, seed;
  // ********************************
  // Harness
  // ********************************
  dual_serial_register_slave dut (.clock_i, .srst_i, .csb_n_i, .sck_i, .sdi_i, .sdi_o, .sdi_oe_n_o, .sdo_i,
    .sdo_o, .sdo_oe_n_o, .core_we_i, .core_addr_i, .core_wdata_i, .core_rdata_o, .host_wr_o, .host_wr_addr_o,
    .host_wr_data_o, .three_wire_enable_o, .i2c_disabled_o, .spi_mode_o);
  serial_host_model h (.dut_sdi_i(sdi_o), .dut_sdi_oe_n_i(sdi_oe_n_o), .dut_sdo_i(sdo_o),
    .dut_sdo_oe_n_i(sdo_oe_n_o), .csb_n_o(csb_n_i), .sck_o(sck_i), .pad_o(sdi_i));
  initial clock_i = 1'b0;
  always #12.5 clock_i = ~clock_i;
  always @(negedge clock_i) begin
    if (host_wr_o === 1'b1) begin
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx;
      `check("host write", exp_w, {host_wr_addr_o, host_wr_data_o})
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic drain();
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(negedge clock_i);
    `check("pending writes", 0, exp_q.size())
  endtask
  task automatic i2c_tx(input logic [7:0] b, input logic exp_ack);
    h.i2c_byte(b, 1'b1, rx, ack);
    `check("two-wire ack", exp_ack, ack)
  endtask
  task automatic core_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock_i);
    core_we_i = 1'b1;
    core_addr_i = a;
    core_wdata_i = v;
    @(negedge clock_i);
    core_we_i = 1'b0;
  endtask
  task automatic core_rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge clock_i);
    core_addr_i = a;
    @(negedge clock_i);
    `check("core read", x, core_rdata_o)
  endtask
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    repeat (40000) @(posedge clock_i);
    num_errors++;
    $display("Error run expected done seen hang");
    end_of_test();
  end
  initial begin
    seed = 32'h8161_2205;
    srst_i = 1'b0;
    sdo_i = 1'b0;
    core_we_i = 1'b0;
    core_addr_i = 8'h00;
    core_wdata_i = 8'h00;
    for (int k = 0; k < 2; k++) d[k] = 8'($random(seed));
    for (int k = 0; k < 3; k++) e[k] = 8'($random(seed));
    base = {2'b01, 6'($random(seed))};
    // Raised after time zero so the link's asynchronous clear sees an edge
    #1 srst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    srst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    `check("idle pads", 4'hc, {sdi_oe_n_o, sdo_oe_n_o, i2c_disabled_o, three_wire_enable_o})
    h.i2c_start();
    i2c_tx({I2C_ADDR_FIXED, 2'b00}, 1'b0);
    for (int k = 0; k < 2; k++) begin
      i2c_tx(base + 8'(k), 1'b0);
      exp_q.push_back({base + 8'(k), d[k]});
      i2c_tx(d[k], 1'b0);
    end
    h.i2c_stop();
    h.i2c_start();
    i2c_tx({I2C_ADDR_FIXED, 2'b10}, 1'b1);
    h.i2c_stop();
    sdo_i = 1'b1;
    h.i2c_start();
    i2c_tx({I2C_ADDR_FIXED, 2'b10}, 1'b0);
    i2c_tx(base, 1'b0);
    h.i2c_start();
    i2c_tx({I2C_ADDR_FIXED, 2'b11}, 1'b0);
    for (int k = 0; k < 2; k++) begin
      h.i2c_byte(8'hff, k[0], rx, ack);
      `check("two-wire read", d[k], rx)
    end
    h.i2c_stop();
    core_rd(base + 8'h01, d[1]);
    core_wr(8'h80, e[0]);
    core_wr(8'h81, e[1]);
    h.spi_begin(1'b1);
    h.spi_byte(8'h80, rx);
    for (int k = 0; k < 2; k++) begin
      h.spi_byte(8'hff, rx);
      `check("spi read", e[k], rx)
    end
    h.spi_end(1'b1);
    `check("mode and lock", 2'b11, {spi_mode_o, i2c_disabled_o})
    h.spi_begin(1'b0);
    h.spi_byte(8'h75, rx);
    exp_q.push_back({CONFIG_ADDR, 8'h01});
    h.spi_byte(8'h01, rx);
    h.spi_byte(8'h02, rx);
    exp_q.push_back({8'h82, e[2]});
    h.spi_byte(e[2], rx);
    h.spi_end(1'b0);
    drain();
    `check("three-wire set", 2'b10, {three_wire_enable_o, spi_mode_o})
    core_rd(8'h82, e[2]);
    h.spi_begin(1'b1);
    h.spi_byte(8'h81, rx);
    for (int k = 1; k < 3; k++) begin
      h.spi_byte(8'hff, rx);
      `check("three-wire read", e[k], rx)
    end
    h.spi_end(1'b1);
    h.i2c_start();
    i2c_tx({I2C_ADDR_FIXED, 2'b10}, 1'b1);
    h.i2c_stop();
    drain();
    end_of_test();
  end
endmodule
`undef check
`default_nettype wire
